// *** hw/rwpc_pkg.sv ***
// constants and types shared by the reset and wake power control block
// assumes a single 200 MHz clock and a plain strobe register port
package rwpc_pkg;

	// --------------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------------
	localparam logic [7:0]  RWPC_OFS_WAKE1       = 8'h10;
	localparam logic [7:0]  RWPC_OFS_WAKE2       = 8'h14;
	localparam logic [7:0]  RWPC_OFS_RSTCTL      = 8'h50;

	// --------------------------------------------------------------------
	// wake phase supply setup layout
	// --------------------------------------------------------------------
	localparam logic [31:0] RWPC_WAKE_RESET      = 32'h0010_0020;
	localparam logic [31:0] RWPC_WAKE_WMASK      = 32'h001f_4331;
	localparam int          RWPC_BIT_CORE_EN     = 0;
	localparam int          RWPC_BIT_ANA_EN      = 1;
	localparam int          RWPC_BIT_PLL_EN      = 4;
	localparam int          RWPC_BIT_IO_EN       = 5;
	localparam int          RWPC_BIT_CORE_PFM    = 8;
	localparam int          RWPC_BIT_ANA_PFM     = 9;
	localparam int          RWPC_BIT_CLK_OFF     = 14;
	localparam int          RWPC_DWELL_LSB       = 16;
	localparam int          RWPC_DWELL_W         = 5;

	// --------------------------------------------------------------------
	// reset and mode control layout
	// --------------------------------------------------------------------
	localparam int          RWPC_BIT_SW_SYS      = 0;
	localparam int          RWPC_BIT_SW_TILE     = 1;
	localparam int          RWPC_MODE_LSB        = 8;
	localparam int          RWPC_MODE_W          = 8;
	localparam int          RWPC_BIT_STAT_SYS    = 16;
	localparam int          RWPC_BIT_STAT_TILE   = 17;
	localparam int          RWPC_STATE_LSB       = 24;
	localparam logic [7:0]  RWPC_MODE_RESET      = 8'h00;

	// --------------------------------------------------------------------
	// reset timing
	// --------------------------------------------------------------------
	localparam int          RWPC_SYS_RST_OSC     = 524288;
	localparam int          RWPC_TILE_RST_CYCLES = 16;

	typedef enum logic [1:0] {
		RWPC_IDLE,
		RWPC_WAKE1,
		RWPC_WAKE2,
		RWPC_AWAKE
	} rwpc_state_type;

	typedef struct packed {
		logic tile_clk_off;
		logic analogue_pfm;
		logic core_pfm;
		logic io_supply_output_en;
		logic pll_linear_regulator_en;
		logic analogue_buck_converter_en;
		logic core_buck_converter_en;
	} rwpc_supply_type;

endpackage

// *** hw/rwpc_top.sv ***
// reset generation and wake phase supply sequencing
// assumes all inputs except the async i_rst synchronous to i_clk; i_osc_tick pulses once per oscillator cycle
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module rwpc_top #(
	parameter int SYS_RST_OSC = rwpc_pkg::RWPC_SYS_RST_OSC
) (
	input  wire logic                      i_clk,          // 200 MHz clock
	input  wire logic                      i_rst,          // async reset, active high
	input  wire logic [7:0]                i_addr,         // register byte address
	input  wire logic [31:0]               i_wdata,        // write data
	input  wire logic                      i_wr,           // write strobe
	input  wire logic                      i_rd,           // read strobe
	output logic      [31:0]               o_rdata,        // read data, cycle after i_rd
	input  wire logic                      i_rst_pin_n,    // external reset pin, active low
	input  wire logic                      i_brownout,     // any supply browned out
	input  wire logic                      i_wdog_expire,  // watchdog expiry
	input  wire logic                      i_sleep_seq,    // sleep sequence running
	input  wire logic                      i_clk_src_chg,  // clock source change
	input  wire logic                      i_osc_tick,     // one oscillator cycle
	input  wire logic                      i_wake_start,   // start wake sequence
	input  wire logic [3:0]                i_supply_good,  // {io, pll, analogue, core}
	output logic                           o_sys_rst,      // system reset, active high
	output logic                           o_tile_rst,     // tile reset, active high
	output rwpc_pkg::rwpc_supply_type      o_supply,       // supply controls
	output rwpc_pkg::rwpc_state_type       o_state,        // wake sequencer state
	output logic                           o_awake         // wake sequence complete
);

	localparam int SYS_CW  = $clog2(SYS_RST_OSC);
	localparam int TILE_CW = $clog2(rwpc_pkg::RWPC_TILE_RST_CYCLES);

	// --------------------------------------------------------------------
	// register file
	// --------------------------------------------------------------------
	logic [31:0] wake1_r;
	logic [31:0] wake1_nxt;
	logic [31:0] wake2_r;
	logic [31:0] wake2_nxt;
	logic [7:0]  mode_r;
	logic [7:0]  mode_nxt;
	logic        sw_sys;
	logic        sw_tile;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	rwpc_pkg::rwpc_state_type state_r;
	rwpc_pkg::rwpc_state_type state_nxt;
	logic                     sys_rst_r;
	logic                     tile_rst_r;

	always_comb
	begin
		wake1_nxt = wake1_r;
		wake2_nxt = wake2_r;
		mode_nxt  = mode_r;
		sw_sys    = 1'b0;
		sw_tile   = 1'b0;
		rdata_nxt = 32'h0000_0000;
		if (i_wr)
		begin
			unique case (i_addr)
				rwpc_pkg::RWPC_OFS_WAKE1:
					wake1_nxt = i_wdata & rwpc_pkg::RWPC_WAKE_WMASK;
				rwpc_pkg::RWPC_OFS_WAKE2:
					wake2_nxt = i_wdata & rwpc_pkg::RWPC_WAKE_WMASK;
				rwpc_pkg::RWPC_OFS_RSTCTL:
				begin
					sw_sys   = i_wdata[rwpc_pkg::RWPC_BIT_SW_SYS];
					sw_tile  = i_wdata[rwpc_pkg::RWPC_BIT_SW_TILE];
					mode_nxt = i_wdata[rwpc_pkg::RWPC_MODE_LSB +: rwpc_pkg::RWPC_MODE_W];
				end
				default:
				begin
				end
			endcase
		end
		if (i_rd)
		begin
			unique case (i_addr)
				rwpc_pkg::RWPC_OFS_WAKE1:
					rdata_nxt = wake1_r;
				rwpc_pkg::RWPC_OFS_WAKE2:
					rdata_nxt = wake2_r;
				rwpc_pkg::RWPC_OFS_RSTCTL:
				begin
					// trigger bits are self-clearing and read as zero
					rdata_nxt[rwpc_pkg::RWPC_MODE_LSB +: rwpc_pkg::RWPC_MODE_W] = mode_r;
					rdata_nxt[rwpc_pkg::RWPC_BIT_STAT_SYS]                     = sys_rst_r;
					rdata_nxt[rwpc_pkg::RWPC_BIT_STAT_TILE]                    = tile_rst_r;
					rdata_nxt[rwpc_pkg::RWPC_STATE_LSB +: 2]                   = state_r;
				end
				default:
					rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wake1_r <= rwpc_pkg::RWPC_WAKE_RESET;
			wake2_r <= rwpc_pkg::RWPC_WAKE_RESET;
			mode_r  <= rwpc_pkg::RWPC_MODE_RESET;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			wake1_r <= wake1_nxt;
			wake2_r <= wake2_nxt;
			mode_r  <= mode_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;

	// --------------------------------------------------------------------
	// reset generation
	// --------------------------------------------------------------------
	logic [SYS_CW-1:0]  sys_cnt_r;
	logic [SYS_CW-1:0]  sys_cnt_nxt;
	logic               sys_rst_nxt;
	logic [TILE_CW-1:0] tile_cnt_r;
	logic [TILE_CW-1:0] tile_cnt_nxt;
	logic               tile_rst_nxt;
	logic               sys_src;
	logic               tile_src;

	// a held pin restarts the count every cycle, so the full length runs after release
	assign sys_src  = !i_rst_pin_n || i_brownout || i_wdog_expire || sw_sys;
	assign tile_src = i_sleep_seq || i_clk_src_chg || sw_tile || sys_rst_r;

	always_comb
	begin
		sys_rst_nxt  = sys_rst_r;
		sys_cnt_nxt  = sys_cnt_r;
		tile_rst_nxt = tile_rst_r;
		tile_cnt_nxt = tile_cnt_r;
		if (sys_src)
		begin
			sys_rst_nxt = 1'b1;
			sys_cnt_nxt = '0;
		end
		else if (sys_rst_r && i_osc_tick)
		begin
			// counted in oscillator cycles: a slower oscillator gives a longer reset
			if (sys_cnt_r == SYS_CW'(SYS_RST_OSC - 1))
			begin
				sys_rst_nxt = 1'b0;
				sys_cnt_nxt = '0;
			end
			else
				sys_cnt_nxt = sys_cnt_r + SYS_CW'(1);
		end
		if (tile_src)
		begin
			tile_rst_nxt = 1'b1;
			tile_cnt_nxt = '0;
		end
		else if (tile_rst_r)
		begin
			if (tile_cnt_r == TILE_CW'(rwpc_pkg::RWPC_TILE_RST_CYCLES - 1))
			begin
				tile_rst_nxt = 1'b0;
				tile_cnt_nxt = '0;
			end
			else
				tile_cnt_nxt = tile_cnt_r + TILE_CW'(1);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sys_rst_r  <= 1'b1;
			sys_cnt_r  <= '0;
			tile_rst_r <= 1'b1;
			tile_cnt_r <= '0;
		end
		else
		begin
			sys_rst_r  <= sys_rst_nxt;
			sys_cnt_r  <= sys_cnt_nxt;
			tile_rst_r <= tile_rst_nxt;
			tile_cnt_r <= tile_cnt_nxt;
		end
	end

	assign o_sys_rst  = sys_rst_r;
	assign o_tile_rst = tile_rst_r;

	// --------------------------------------------------------------------
	// wake phase sequencer
	// --------------------------------------------------------------------
	logic [31:0]     cur_cfg;
	logic [31:0]     dwell_r;
	logic [31:0]     dwell_nxt;
	logic [31:0]     dwell_lim;
	logic [3:0]      en_vec;
	logic            all_good;
	logic            dwell_met;
	rwpc_pkg::rwpc_supply_type supply_r;
	rwpc_pkg::rwpc_supply_type supply_nxt;

	always_comb
	begin
		unique case (state_r)
			rwpc_pkg::RWPC_WAKE1:
				cur_cfg = wake1_r;
			rwpc_pkg::RWPC_WAKE2, rwpc_pkg::RWPC_AWAKE:
				cur_cfg = wake2_r;
			rwpc_pkg::RWPC_IDLE:
				cur_cfg = 32'h0000_0000;
		endcase
	end

	// 2^n cycles; n of 31 still fits 32 bits
	assign dwell_lim = (32'h0000_0001 << cur_cfg[rwpc_pkg::RWPC_DWELL_LSB +: rwpc_pkg::RWPC_DWELL_W])
		- 32'h0000_0001;
	assign dwell_met = dwell_r >= dwell_lim;
	assign en_vec    = {cur_cfg[rwpc_pkg::RWPC_BIT_IO_EN], cur_cfg[rwpc_pkg::RWPC_BIT_PLL_EN],
		cur_cfg[rwpc_pkg::RWPC_BIT_ANA_EN], cur_cfg[rwpc_pkg::RWPC_BIT_CORE_EN]};
	assign all_good  = &(i_supply_good | ~en_vec);

	always_comb
	begin
		state_nxt = state_r;
		dwell_nxt = (dwell_r == 32'hffff_ffff) ? dwell_r : dwell_r + 32'h0000_0001;
		unique case (state_r)
			rwpc_pkg::RWPC_IDLE:
				if (i_wake_start)
					state_nxt = rwpc_pkg::RWPC_WAKE1;
			rwpc_pkg::RWPC_WAKE1:
				if (dwell_met && all_good)
					state_nxt = rwpc_pkg::RWPC_WAKE2;
			rwpc_pkg::RWPC_WAKE2:
				if (dwell_met && all_good)
					state_nxt = rwpc_pkg::RWPC_AWAKE;
			rwpc_pkg::RWPC_AWAKE:
				state_nxt = rwpc_pkg::RWPC_AWAKE;
		endcase
		if (sys_rst_r)
			state_nxt = rwpc_pkg::RWPC_IDLE;
		if (state_nxt != state_r)
			dwell_nxt = 32'h0000_0000;
		supply_nxt.tile_clk_off               = cur_cfg[rwpc_pkg::RWPC_BIT_CLK_OFF];
		supply_nxt.analogue_pfm               = cur_cfg[rwpc_pkg::RWPC_BIT_ANA_PFM];
		supply_nxt.core_pfm                   = cur_cfg[rwpc_pkg::RWPC_BIT_CORE_PFM];
		supply_nxt.io_supply_output_en        = cur_cfg[rwpc_pkg::RWPC_BIT_IO_EN];
		supply_nxt.pll_linear_regulator_en    = cur_cfg[rwpc_pkg::RWPC_BIT_PLL_EN];
		supply_nxt.analogue_buck_converter_en = cur_cfg[rwpc_pkg::RWPC_BIT_ANA_EN];
		supply_nxt.core_buck_converter_en     = cur_cfg[rwpc_pkg::RWPC_BIT_CORE_EN];
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r  <= rwpc_pkg::RWPC_IDLE;
			dwell_r  <= 32'h0000_0000;
			supply_r <= '0;
		end
		else
		begin
			state_r  <= state_nxt;
			dwell_r  <= dwell_nxt;
			supply_r <= supply_nxt;
		end
	end

	assign o_supply = supply_r;
	assign o_state  = state_r;
	assign o_awake  = (state_r == rwpc_pkg::RWPC_AWAKE);

	// --------------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sys_src_a: assert property (sys_src |=> o_sys_rst)
		else $error("system reset source did not raise system reset");
	sw_reset_a: assert property (i_wr && i_addr == rwpc_pkg::RWPC_OFS_RSTCTL
		&& i_wdata[rwpc_pkg::RWPC_BIT_SW_TILE] |=> o_tile_rst)
		else $error("software tile reset not raised");
	tile_src_a: assert property ((i_sleep_seq || i_clk_src_chg) |=> o_tile_rst [*2])
		else $error("tile reset not raised on sleep or clock change");
	scope_nest_a: assert property (o_sys_rst |=> o_tile_rst)
		else $error("system reset did not cover the tiles");
	sys_length_a: assert property ($fell(o_sys_rst) |-> $past(i_osc_tick)
		&& $past(sys_cnt_r) == SYS_CW'(SYS_RST_OSC - 1))
		else $error("system reset ended before full oscillator count");
	dwell_hold_a: assert property (state_r == rwpc_pkg::RWPC_WAKE1 && !sys_rst_r
		&& (!dwell_met || !all_good) |=> state_r == rwpc_pkg::RWPC_WAKE1)
		else $error("wake phase one left early");
	dwell_one_a: assert property (state_r == rwpc_pkg::RWPC_WAKE1 && $changed(state_r)
		&& wake1_r[rwpc_pkg::RWPC_DWELL_LSB +: rwpc_pkg::RWPC_DWELL_W] == 5'h00
		&& all_good && !sys_rst_r |=> state_r == rwpc_pkg::RWPC_WAKE2)
		else $error("one-cycle dwell not honoured");
	clk_gate_a: assert property (state_r == rwpc_pkg::RWPC_WAKE2 && $stable(state_r)
		&& $stable(wake2_r) |-> o_supply.tile_clk_off == wake2_r[rwpc_pkg::RWPC_BIT_CLK_OFF])
		else $error("tile clock gate does not follow phase two setup");
	reserved_zero_a: assert property ((wake1_r & ~rwpc_pkg::RWPC_WAKE_WMASK) == 32'h0
		&& !wake2_r[rwpc_pkg::RWPC_BIT_ANA_EN])
		else $error("reserved or read-only bit became set");

	wake_done_c: cover property (state_r == rwpc_pkg::RWPC_WAKE2 ##1 o_awake);
	sw_sys_c:    cover property (sw_sys ##1 o_sys_rst);
	clk_chg_c:   cover property (i_clk_src_chg && !o_sys_rst ##1 o_tile_rst);

endmodule

// *** verif/rwpc_supply_model.sv ***
// behavioural model of the supply regulators behind the wake sequencer
// assumes enables come registered from the design; the bench sets the delay
`timescale 1ns/100ps
module rwpc_supply_model (
	input  wire logic                      i_clk,    // design clock
	input  wire logic                      i_rst,    // async reset, active high
	input  wire rwpc_pkg::rwpc_supply_type i_supply, // enables from the design
	input  wire logic [7:0]                i_dly,    // cycles from enable to good
	output logic      [3:0]                o_good    // {io, pll, analogue, core}
);
	logic [3:0] en;
	logic [7:0] cnt_r [4];
	logic [7:0] cnt_nxt [4];

	assign en = {i_supply.io_supply_output_en, i_supply.pll_linear_regulator_en,
		i_supply.analogue_buck_converter_en, i_supply.core_buck_converter_en};

	// a supply that is off never reports good, so no wait can be skipped
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			cnt_nxt[i] = (!en[i]) ? 8'h00 : (cnt_r[i] == 8'hff) ? cnt_r[i] : cnt_r[i] + 8'h01;
			o_good[i] = en[i] && (cnt_r[i] >= i_dly);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		for (int i = 0; i < 4; i++)
			cnt_r[i] <= i_rst ? 8'h00 : cnt_nxt[i];
	end
endmodule

// *** verif/rwpc_top_tb.sv ***
// self-checking bench for the reset and wake power control block
// assumes the design and the supply model are compiled first
`timescale 1ns/100ps
module rwpc_top_tb;
	localparam int NOSC  = 8;
	localparam int NTILE = 16;
	logic        i_clk, i_rst, i_wr, i_rd, i_rst_pin_n, i_brownout, i_wdog_expire;
	logic        i_sleep_seq, i_clk_src_chg, i_osc_tick, i_wake_start;
	logic        o_sys_rst, o_tile_rst, o_awake, rd_d, sys_d;
	logic [7:0]  i_addr, dly;
	logic [31:0] i_wdata, o_rdata, lfsr;
	logic [3:0]  i_supply_good;
	logic [31:0] exp_q[$];
	int          miscompares, n_tests, cyc, osc_n, ph;
	rwpc_pkg::rwpc_supply_type o_supply;
	rwpc_pkg::rwpc_state_type  o_state;

	rwpc_top #(.SYS_RST_OSC(NOSC)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_rst_pin_n(i_rst_pin_n), .i_brownout(i_brownout), .i_wdog_expire(i_wdog_expire),
		.i_sleep_seq(i_sleep_seq), .i_clk_src_chg(i_clk_src_chg), .i_osc_tick(i_osc_tick),
		.i_wake_start(i_wake_start), .i_supply_good(i_supply_good), .o_sys_rst(o_sys_rst),
		.o_tile_rst(o_tile_rst), .o_supply(o_supply), .o_state(o_state), .o_awake(o_awake));
	rwpc_supply_model model_u (.i_clk(i_clk), .i_rst(i_rst), .i_supply(o_supply),
		.i_dly(dly), .o_good(i_supply_good));

	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// --------------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a gap cycle after each strobe keeps every signal to one assignment per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic rwpc_pkg::rwpc_supply_type sup(input logic [31:0] v);
		return {v[14], v[9], v[8], v[5], v[4], 1'b0, v[0]};
	endfunction

	// k: 0 pin, 1 brown-out, 2 watchdog, 3 sleep, 4 clock change, 5 sw tile, 6 sw system
	task automatic pulse(input int k);
		int n;
		n = 0;
		case (k)
			0: i_rst_pin_n <= 1'b0;
			1: i_brownout <= 1'b1;
			2: i_wdog_expire <= 1'b1;
			3: i_sleep_seq <= 1'b1;
			4: i_clk_src_chg <= 1'b1;
			default:
			begin
				i_addr <= rwpc_pkg::RWPC_OFS_RSTCTL;
				i_wdata <= (k == 5) ? 32'h0000_0002 : 32'h0000_0001;
				i_wr <= 1'b1;
			end
		endcase
		@(posedge i_clk);
		i_rst_pin_n <= 1'b1;
		i_brownout <= 1'b0;
		i_wdog_expire <= 1'b0;
		i_sleep_seq <= 1'b0;
		i_clk_src_chg <= 1'b0;
		i_wr <= 1'b0;
		@(posedge i_clk);
		chk("system reset", (k < 3 || k == 6), o_sys_rst);
		// a system reset reaches the tiles one clock after it rises
		if (k < 3 || k == 6)
			@(posedge i_clk);
		chk("tile reset up", 32'h1, o_tile_rst);
		while (o_tile_rst === 1'b1 && n < 1000)
		begin
			n++;
			@(posedge i_clk);
		end
		if (k >= 3 && k <= 5)
			chk("tile reset length", NTILE, n);
		$display("test reset source %0d done", k);
	endtask

	task automatic wake(input logic [31:0] w1, input logic [31:0] w2, input logic [7:0] d);
		int n;
		int dw;
		dly <= d;
		wr(rwpc_pkg::RWPC_OFS_WAKE1, w1);
		wr(rwpc_pkg::RWPC_OFS_WAKE2, w2);
		i_wake_start <= 1'b1;
		@(posedge i_clk);
		i_wake_start <= 1'b0;
		@(posedge i_clk);
		for (int p = 1; p <= 2; p++)
		begin
			n = 0;
			dw = 1 << ((p == 1) ? w1[20:16] : w2[20:16]);
			while (o_state === 2'(p) && n < 5000)
			begin
				n++;
				if (n == 2)
					chk("supply", sup((p == 1) ? w1 : w2), o_supply);
				@(posedge i_clk);
			end
			if (d < 2)
				chk("dwell", dw, n);
			else
				chk("wait for good", 32'h1, n > dw);
		end
		chk("awake", 32'h1, o_awake);
		pulse(6);
		chk("idle after reset", 32'h0, o_state);
		$display("test wake sequence done");
	endtask

	// --------------------------------------------------------------------
	// monitors
	// --------------------------------------------------------------------
	always @(posedge i_clk)
	begin
		cyc++;
		rd_d <= i_rd;
		sys_d <= o_sys_rst;
		ph = (ph + 1) % 3;
		i_osc_tick <= (ph == 0);
		if (i_rst || !i_rst_pin_n || i_brownout || i_wdog_expire
			|| (i_wr && i_addr == rwpc_pkg::RWPC_OFS_RSTCTL && i_wdata[0]))
			osc_n = 0;
		else if (o_sys_rst === 1'b1 && i_osc_tick)
			osc_n++;
		if (sys_d === 1'b1 && o_sys_rst === 1'b0)
			chk("system reset ticks", NOSC, osc_n);
		if (cyc == 20000)
		begin
			miscompares++;
			$display("ERROR timeout expected finish seen hang");
			end_sim();
		end
	end

	always @(negedge i_clk)
	begin
		if (rd_d === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("read queue", 32'h1, 32'h0);
			else
				chk("read data", exp_q.pop_front(), o_rdata);
		end
	end

	// --------------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------------
	initial
	begin
		{i_wr, i_rd, i_brownout, i_wdog_expire, i_sleep_seq} = '0;
		{i_clk_src_chg, i_osc_tick, i_wake_start, rd_d, sys_d} = '0;
		i_rst = 1'b1;
		i_rst_pin_n = 1'b1;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		dly = 8'h01;
		lfsr = 32'h5a;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		while (o_tile_rst !== 1'b0 && cyc < 1000)
			@(posedge i_clk);
		rd(rwpc_pkg::RWPC_OFS_WAKE1, 32'h0010_0020);
		rd(rwpc_pkg::RWPC_OFS_WAKE2, 32'h0010_0020);
		rd(rwpc_pkg::RWPC_OFS_RSTCTL, 32'h0);
		rd(8'h20, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			lfsr = nxt(lfsr);
			wr(rwpc_pkg::RWPC_OFS_WAKE1, lfsr);
			rd(rwpc_pkg::RWPC_OFS_WAKE1, lfsr & 32'h001f_4331);
			wr(rwpc_pkg::RWPC_OFS_WAKE2, ~lfsr);
			rd(rwpc_pkg::RWPC_OFS_WAKE2, ~lfsr & 32'h001f_4331);
			wr(rwpc_pkg::RWPC_OFS_RSTCTL, lfsr & 32'h0000_ff00);
			rd(rwpc_pkg::RWPC_OFS_RSTCTL, lfsr & 32'h0000_ff00);
		end
		$display("test register access done");
		for (int k = 0; k <= 6; k++)
			pulse(k);
		wake(32'h0003_4331, 32'h0002_0021, 8'h01);
		wake(32'h0002_0020, 32'h0001_0230, 8'h28);
		wake(32'h0000_0000, 32'h0003_0021, 8'h01);
		end_sim();
	end
endmodule
